//--- include/bct_pkg.sv
// Package: constants, types and register map of the bus clear/trigger block
// Function
// - Universal device clear restores every setting to its power-up default.
// - Universal device clear acts without addressing; all devices clear together.
// - Universal device clear keeps the programmed primary bus address.
// - Selective device clear is honoured only while addressed as listener.
// - Selective device clear reruns power-up and restores default configuration.
// - Group trigger starts a cycle only if selected origin and enabled.
// - Serial poll may run any time; device returns its status byte.
// - Serial poll byte shows whether this device asserts service request.
// - After power-up or clear, EOI enabled and hold-off on execute.
// - After power-up or clear, ASCII with prefix, source only, one line.
// - After power-up or clear, SRQ mask empty; compliance SRQ idle/measure/delay.
// - Power-up and clear keep sweep buffer; only factory init empties it (here reset also empties it).
// - Trigger during a running phase is ignored but flags overrun.
`default_nettype none
package bct_pkg;
    // Register word addresses
    localparam logic [3:0] ADDR_CONFIG  = 4'h0;
    localparam logic [3:0] ADDR_TRIG    = 4'h1;
    localparam logic [3:0] ADDR_SRQMASK = 4'h2;
    localparam logic [3:0] ADDR_STATUS  = 4'h3;
    localparam logic [3:0] ADDR_IRQSTAT = 4'h4;
    localparam logic [3:0] ADDR_IRQMASK = 4'h5;
    localparam logic [3:0] ADDR_ADDRESS = 4'h6;
    localparam logic [3:0] ADDR_SWEEP   = 4'h7;
    localparam logic [3:0] ADDR_CMD     = 4'h8;
    // Bus command codes (low seven bits of a command byte)
    localparam logic [6:0] CMD_DCL = 7'h14;
    localparam logic [6:0] CMD_SDC = 7'h04;
    localparam logic [6:0] CMD_GET = 7'h08;
    localparam logic [6:0] CMD_SPE = 7'h18;
    localparam logic [6:0] CMD_SPD = 7'h19;
    localparam logic [6:0] CMD_UNL = 7'h3f;
    localparam logic [6:0] CMD_UNT = 7'h5f;
    localparam logic [1:0] GRP_LISTEN = 2'h1;
    localparam logic [1:0] GRP_TALK   = 2'h2;
    // Defaults and timing
    localparam logic [4:0] ADDR_RESET    = 5'h10;
    localparam logic [2:0] ORIGIN_GET    = 3'h1;
    localparam logic [7:0] PHASE_CYCLES  = 8'h20;
    localparam logic [3:0] CLEAR_CYCLES  = 4'h8;
    // Interrupt and poll byte bit positions
    localparam int IRQ_CLEAR   = 0;
    localparam int IRQ_TRIG    = 1;
    localparam int IRQ_OVERRUN = 2;
    localparam int IRQ_SPOLL   = 3;
    localparam int SPB_SRQ     = 6;

    // Programmable settings restored by device clear
    typedef struct packed {
        logic       operate;     // 0 = standby
        logic [1:0] function_sel;// 0 = dc
        logic       remote_sense;
        logic       suppress;
        logic       eoi_en;
        logic       holdoff_x;
        logic [1:0] out_items;   // 1 = source value only
        logic [1:0] out_format;  // 0 = ASCII prefix suffix
        logic [1:0] out_lines;   // 0 = one line dc data
        logic [7:0] srq_mask;
        logic [1:0] compl_srq;   // 0 = idle, measure or delay
        logic [2:0] trig_origin;
        logic       trig_en;
    } bct_cfg_s;

    localparam bct_cfg_s CFG_DEFAULT = '{
        operate: 1'b0, function_sel: 2'h0, remote_sense: 1'b0,
        suppress: 1'b0, eoi_en: 1'b1, holdoff_x: 1'b1,
        out_items: 2'h1, out_format: 2'h0, out_lines: 2'h0,
        srq_mask: 8'h00, compl_srq: 2'h0, trig_origin: 3'h0,
        trig_en: 1'b1};

    // Decoded bus command pulses
    typedef struct packed {
        logic dcl;
        logic sdc;
        logic get;
        logic spe;
        logic spd;
    } bct_cmd_s;

    typedef enum logic [1:0] {
        PH_IDLE    = 2'b00,
        PH_SOURCE  = 2'b01,
        PH_DELAY   = 2'b10,
        PH_MEASURE = 2'b11
    } bct_phase_e;
endpackage
`default_nettype wire

//--- logic/bct_decode.sv
// Bus command decoder and talker/listener addressing state
`timescale 1ns/1ps
`default_nettype none
module bct_decode
    import bct_pkg::*;
(
    input  wire logic           clk_in,
    input  wire logic           rst_n_in,
    input  wire logic           cmd_valid_in,
    input  wire logic [7:0]     cmd_byte_in,
    input  wire logic [4:0]     my_addr_in,
    output bct_pkg::bct_cmd_s   cmd_out,
    output logic                listener_out,
    output logic                talker_out
);
    import bct_pkg::*;

    wire logic [6:0] code     = cmd_byte_in[6:0];
    wire logic       is_mla   = code == {GRP_LISTEN, my_addr_in};
    wire logic       is_mta   = code == {GRP_TALK, my_addr_in};
    wire logic       oth_lst  = code[6:5] == GRP_LISTEN && !is_mla
                                && code != CMD_UNL;
    wire logic       oth_tlk  = code[6:5] == GRP_TALK && !is_mta
                                && code != CMD_UNT;

    // Universal commands need no address; addressed ones need listener
    always_comb
    begin
        cmd_out.dcl = cmd_valid_in && code == CMD_DCL;
        cmd_out.sdc = cmd_valid_in && code == CMD_SDC
                      && listener_out;
        cmd_out.get = cmd_valid_in && code == CMD_GET && listener_out;
        cmd_out.spe = cmd_valid_in && code == CMD_SPE;
        cmd_out.spd = cmd_valid_in && code == CMD_SPD;
    end

    // Listener follows own listen address until unlisten or own talk
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            listener_out <= 1'b0;
            talker_out   <= 1'b0;
        end
        else if (cmd_valid_in)
        begin
            if (is_mla)
                listener_out <= 1'b1;
            else if (code == CMD_UNL || is_mta)
                listener_out <= 1'b0;
            if (is_mta)
                talker_out <= 1'b1;
            else if (code == CMD_UNT || is_mla || oth_tlk)
                talker_out <= 1'b0;
        end
    end

    wire logic unused_ok = oth_lst;
endmodule
`default_nettype wire

//--- logic/bct_phase.sv
// Source-delay-measure phase sequencer with overrun detection
`timescale 1ns/1ps
`default_nettype none
module bct_phase
    import bct_pkg::*;
#(
    parameter logic [7:0] PHASE_LEN = PHASE_CYCLES
)
(
    input  wire logic           clk_in,
    input  wire logic           rst_n_in,
    input  wire logic           abort_in,
    input  wire logic           trig_in,
    output bct_pkg::bct_phase_e phase_out,
    output logic                start_out,
    output logic                overrun_out
);
    import bct_pkg::*;

    logic [7:0]  count;
    bct_phase_e  next_phase;
    wire logic   busy = phase_out != PH_IDLE;
    wire logic   done = count == PHASE_LEN - 8'h01;

    // A trigger while busy is dropped and only flagged
    assign start_out   = trig_in && !busy;
    assign overrun_out = trig_in && busy;

    always_comb
    begin
        next_phase = phase_out;
        case (phase_out)
            PH_IDLE:    if (start_out) next_phase = PH_SOURCE;
            PH_SOURCE:  if (done) next_phase = PH_DELAY;
            PH_DELAY:   if (done) next_phase = PH_MEASURE;
            PH_MEASURE: if (done) next_phase = PH_IDLE;
            default:    next_phase = PH_IDLE;
        endcase
    end

    // Each phase lasts a fixed count; clear aborts the cycle
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            phase_out <= PH_IDLE;
            count     <= 8'h00;
        end
        else if (abort_in)
        begin
            phase_out <= PH_IDLE;
            count     <= 8'h00;
        end
        else
        begin
            phase_out <= next_phase;
            count     <= (next_phase != phase_out) ? 8'h00 : count + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- logic/bct_top.sv
// Device-side bus clear, group trigger and serial poll handling
`timescale 1ns/1ps
`default_nettype none
module bct_top
    import bct_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    // Bus command byte stream (ATN true)
    input  wire logic        cmd_valid_in,
    input  wire logic [7:0]  cmd_byte_in,
    // Device status inputs
    input  wire logic [5:0]  dev_status_in,
    input  wire logic        factory_init_in,
    // Outputs
    output logic             srq_out,
    output logic [7:0]       spoll_byte_out,
    output logic             spoll_active_out,
    output logic             listener_out,
    output logic             talker_out,
    output logic             clearing_out,
    output logic [1:0]       phase_out,
    output logic             irq_out
);
    import bct_pkg::*;

    logic [1:0]  rst_sync;
    wire  logic  rst_n = rst_sync[1];
    bct_cfg_s    cfg;
    logic [4:0]  my_addr;
    logic [7:0]  sweep_buf;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic [3:0]  clr_cnt;
    logic        spoll_mode;
    logic        rd_ack;
    bct_cmd_s    cmd;
    bct_phase_e  phase;
    logic        start;
    logic        overrun;

    // Reset release through two flops
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end

    bct_decode bct_decode_inst (
        .clk_in       (mclk_in),
        .rst_n_in     (rst_n),
        .cmd_valid_in (cmd_valid_in),
        .cmd_byte_in  (cmd_byte_in),
        .my_addr_in   (my_addr),
        .cmd_out      (cmd),
        .listener_out (listener_out),
        .talker_out   (talker_out)
    );

    // Both clears act alike once accepted
    wire logic dev_clear = cmd.dcl | cmd.sdc;
    // Trigger qualified by origin and enable, else no effect at all
    wire logic get_trig  = cmd.get && cfg.trig_en
                           && cfg.trig_origin == ORIGIN_GET;
    wire logic sw_trig   = avs_write_in && !avs_waitrequest_out
                           && avs_address_in == ADDR_CMD
                           && avs_writedata_in[0];

    bct_phase bct_phase_inst (
        .clk_in      (mclk_in),
        .rst_n_in    (rst_n),
        .abort_in    (dev_clear),
        .trig_in     (get_trig | sw_trig),
        .phase_out   (phase),
        .start_out   (start),
        .overrun_out (overrun)
    );
    assign phase_out = phase;

    // Bus write decode
    wire logic wr     = avs_write_in && !avs_waitrequest_out;
    wire logic wr_cfg = wr && avs_address_in == ADDR_CONFIG;
    wire logic wr_trg = wr && avs_address_in == ADDR_TRIG;
    wire logic wr_srq = wr && avs_address_in == ADDR_SRQMASK;
    wire logic wr_ist = wr && avs_address_in == ADDR_IRQSTAT;
    wire logic wr_imk = wr && avs_address_in == ADDR_IRQMASK;
    wire logic wr_adr = wr && avs_address_in == ADDR_ADDRESS;
    wire logic wr_swp = wr && avs_address_in == ADDR_SWEEP;

    // Settings: clear beats software write, restores all defaults
    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
            cfg <= CFG_DEFAULT;
        else if (dev_clear)
            cfg <= CFG_DEFAULT;
        else
        begin
            // Config word is the top thirteen bits of the settings struct
            if (wr_cfg)
                cfg[26:14] <= avs_writedata_in[12:0];
            if (wr_srq)
            begin
                cfg.srq_mask  <= avs_writedata_in[7:0];
                cfg.compl_srq <= avs_writedata_in[9:8];
            end
            if (wr_trg)
            begin
                cfg.trig_origin <= avs_writedata_in[2:0];
                cfg.trig_en     <= avs_writedata_in[3];
            end
        end
    end

    // Address and sweep data survive any device clear
    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            my_addr   <= ADDR_RESET;
            sweep_buf <= 8'h00;
        end
        else
        begin
            if (wr_adr)
                my_addr <= avs_writedata_in[4:0];
            if (factory_init_in)
                sweep_buf <= 8'h00;
            else if (wr_swp)
                sweep_buf <= avs_writedata_in[7:0];
        end
    end

    // Clear sequence busy indicator and serial poll mode
    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clr_cnt    <= 4'h0;
            spoll_mode <= 1'b0;
        end
        else
        begin
            if (dev_clear)
                clr_cnt <= CLEAR_CYCLES;
            else if (clr_cnt != 4'h0)
                clr_cnt <= clr_cnt - 4'h1;
            if (cmd.spe)
                spoll_mode <= 1'b1;
            else if (cmd.spd)
                spoll_mode <= 1'b0;
        end
    end
    assign clearing_out = clr_cnt != 4'h0;

    // Service request from masked status; reported in poll byte bit 6
    wire logic [7:0] srq_src = {2'b00, dev_status_in};
    wire logic       srq_req = |(srq_src & cfg.srq_mask);
    wire logic [7:0] spb     = {1'b0, srq_req, dev_status_in};

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            srq_out          <= 1'b0;
            spoll_byte_out   <= 8'h00;
            spoll_active_out <= 1'b0;
        end
        else
        begin
            srq_out          <= srq_req;
            spoll_byte_out   <= spb;
            spoll_active_out <= spoll_mode && talker_out;
        end
    end

    // Sticky events: set wins over write-one-to-clear
    wire logic [3:0] irq_set = {cmd.spe, overrun, start, dev_clear};
    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_stat <= 4'h0;
            irq_mask <= 4'h0;
        end
        else
        begin
            irq_stat <= (irq_stat & ~(wr_ist ? avs_writedata_in[3:0] : 4'h0))
                        | irq_set;
            if (wr_imk)
                irq_mask <= avs_writedata_in[3:0];
        end
    end
    assign irq_out = |(irq_stat & irq_mask);

    // Read mux; unmapped addresses read zero
    logic [31:0] rd_mux;
    always_comb
    begin
        case (avs_address_in)
            ADDR_CONFIG:  rd_mux = {19'h0, cfg[26:14]};
            ADDR_TRIG:    rd_mux = {28'h0, cfg.trig_en, cfg.trig_origin};
            ADDR_SRQMASK: rd_mux = {22'h0, cfg.compl_srq, cfg.srq_mask};
            ADDR_STATUS:  rd_mux = {19'h0, clearing_out, listener_out,
                                    talker_out, phase, spb};
            ADDR_IRQSTAT: rd_mux = {28'h0, irq_stat};
            ADDR_IRQMASK: rd_mux = {28'h0, irq_mask};
            ADDR_ADDRESS: rd_mux = {27'h0, my_addr};
            ADDR_SWEEP:   rd_mux = {24'h0, sweep_buf};
            default:      rd_mux = 32'h0;
        endcase
    end

    // Reads take one wait cycle; writes complete at once
    assign avs_waitrequest_out = avs_read_in && !rd_ack;
    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_ack           <= 1'b0;
            avs_readdata_out <= 32'h0;
        end
        else
        begin
            rd_ack <= avs_read_in && !rd_ack;
            if (avs_read_in && !rd_ack)
                avs_readdata_out <= rd_mux;
        end
    end

    // Checks
    property p_clear_defaults;
        @(posedge mclk_in) disable iff (!rst_n)
        dev_clear |=> cfg == CFG_DEFAULT && clr_cnt == CLEAR_CYCLES;
    endproperty
    a_clear_defaults: assert property (p_clear_defaults)
        else $error("Clear did not restore defaults");

    property p_dcl_unaddressed;
        @(posedge mclk_in) disable iff (!rst_n)
        (cmd_valid_in && cmd_byte_in[6:0] == CMD_DCL) |-> dev_clear;
    endproperty
    a_dcl_unaddressed: assert property (p_dcl_unaddressed)
        else $error("Universal clear not honoured");

    property p_addr_kept;
        @(posedge mclk_in) disable iff (!rst_n)
        (dev_clear && !wr_adr) |=> $stable(my_addr);
    endproperty
    a_addr_kept: assert property (p_addr_kept)
        else $error("Clear changed the bus address");

    property p_sdc_addressed;
        @(posedge mclk_in) disable iff (!rst_n)
        cmd.sdc |-> listener_out;
    endproperty
    a_sdc_addressed: assert property (p_sdc_addressed)
        else $error("Selective clear while unaddressed");

    sequence s_sdc;
        cmd.sdc ##1 clearing_out[*8];
    endsequence
    property p_sdc_seq;
        @(posedge mclk_in) disable iff (!rst_n)
        cmd.sdc && !cmd.dcl |-> s_sdc;
    endproperty
    a_sdc_seq: assert property (p_sdc_seq)
        else $error("Selective clear sequence too short");

    property p_get_start;
        @(posedge mclk_in) disable iff (!rst_n)
        (get_trig && phase == PH_IDLE && !dev_clear) |=> phase == PH_SOURCE;
    endproperty
    a_get_start: assert property (p_get_start)
        else $error("Qualified trigger did not start cycle");

    property p_spoll_srq;
        @(posedge mclk_in) disable iff (!rst_n)
        ##1 spoll_byte_out[SPB_SRQ] == $past(srq_req);
    endproperty
    a_spoll_srq: assert property (p_spoll_srq)
        else $error("Poll byte misreports service request");

    property p_overrun;
        @(posedge mclk_in) disable iff (!rst_n)
        (get_trig && phase != PH_IDLE && !dev_clear)
            |=> irq_stat[IRQ_OVERRUN] && phase != PH_SOURCE | $past(phase)
                == PH_SOURCE;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("Overrun trigger not flagged");

    property p_get_ignored;
        @(posedge mclk_in) disable iff (!rst_n)
        (cmd.get && !get_trig && !sw_trig) |-> !start && !overrun;
    endproperty
    a_get_ignored: assert property (p_get_ignored)
        else $error("Unqualified trigger had an effect");
endmodule
`default_nettype wire

//--- testbench/bct_ctrl_model.sv
// Bus controller model that sends command bytes with ATN true
`timescale 1ns/1ps
`default_nettype none
module bct_ctrl_model
    import bct_pkg::*;
(
    input  wire logic  clk_in,
    output logic       cmd_valid_out,
    output logic [7:0] cmd_byte_out
);
    import bct_pkg::*;
    // Idle lines at time zero
    initial
    begin
        cmd_valid_out = 1'b0;
        cmd_byte_out  = 8'h00;
    end
    // One byte a pulse; a released byte line shows the inverse value
    task automatic send(input logic [7:0] b);
        @(posedge clk_in);
        cmd_valid_out <= 1'b1;
        cmd_byte_out  <= b;
        @(posedge clk_in);
        cmd_valid_out <= 1'b0;
        cmd_byte_out  <= ~b;
    endtask
    // Untalk, unlisten, listen address, then the command
    task automatic addressed(input logic [4:0] a, input logic [6:0] c);
        send({1'b0, CMD_UNT});
        send({1'b0, CMD_UNL});
        send(8'h20 | {3'h0, a});
        send({1'b0, c});
    endtask
    // Poll enable then talk address, at any time
    task automatic poll(input logic [4:0] a);
        send({1'b0, CMD_SPE});
        send(8'h40 | {3'h0, a});
    endtask
endmodule
`default_nettype wire

//--- testbench/bus_clear_trigger_poll_response_tb.sv
// Testbench: device clear, group trigger, serial poll, interrupts
`timescale 1ns/1ps
`default_nettype none
module bus_clear_trigger_poll_response_tb;
    import bct_pkg::*;
    localparam logic [31:0] CFG_RESET = 32'h0d0;
    logic        mclk_in, rst_n_in, avs_read_in, avs_write_in;
    logic [3:0]  avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, q;
    logic        avs_waitrequest_out, cmd_valid_in, factory_init_in;
    logic [7:0]  cmd_byte_in, spoll_byte_out;
    logic [5:0]  dev_status_in;
    logic        srq_out, spoll_active_out, listener_out, talker_out;
    logic        clearing_out, irq_out;
    logic [1:0]  phase_out;
    logic [4:0]  addr;
    int          n_errors, compares;
    string       cur;
    bct_top bct_top_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .cmd_valid_in(cmd_valid_in), .cmd_byte_in(cmd_byte_in),
        .dev_status_in(dev_status_in), .factory_init_in(factory_init_in),
        .srq_out(srq_out), .spoll_byte_out(spoll_byte_out),
        .spoll_active_out(spoll_active_out), .listener_out(listener_out),
        .talker_out(talker_out), .clearing_out(clearing_out),
        .phase_out(phase_out), .irq_out(irq_out));
    bct_ctrl_model ctrl_inst (.clk_in(mclk_in),
        .cmd_valid_out(cmd_valid_in), .cmd_byte_out(cmd_byte_in));
    // Free-running 20 MHz clock
    initial
    begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    task automatic summarize();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, cur, g, e);
        end
    endtask
    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge mclk_in);
        avs_address_in   <= a;
        avs_writedata_in <= d;
        avs_write_in     <= w;
        avs_read_in      <= !w;
        n = 0;
        do
        begin
            @(posedge mclk_in);
            n++;
        end
        while (avs_waitrequest_out !== 1'b0 && n < 50);
        q = avs_readdata_out;
        avs_read_in  <= 1'b0;
        avs_write_in <= 1'b0;
        if (avs_waitrequest_out !== 1'b0)
        begin
            n_errors++;
            summarize();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic chkreg(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic t_reset();
        cur = "reset";
        chkreg(ADDR_CONFIG, CFG_RESET);
        chkreg(ADDR_TRIG, 32'h8);
        chkreg(ADDR_SRQMASK, 32'h0);
        chkreg(ADDR_ADDRESS, {27'h0, ADDR_RESET});
        chkreg(4'h9, 32'h0);
        $display("TEST reset done");
    endtask
    // Universal clear, not addressed, keeps the bus address
    task automatic t_dcl();
        cur = "dcl";
        wr(ADDR_CONFIG, 32'hb3b);
        wr(ADDR_SRQMASK, 32'h3ff);
        wr(ADDR_TRIG, 32'h1);
        wr(ADDR_ADDRESS, 32'h5);
        wr(ADDR_IRQMASK, 32'h0);
        wr(ADDR_IRQSTAT, 32'hf);
        ctrl_inst.send({1'b0, CMD_DCL});
        @(posedge mclk_in);
        chk({31'h0, clearing_out}, 32'h1);
        repeat (12) @(posedge mclk_in);
        chkreg(ADDR_CONFIG, CFG_RESET);
        chkreg(ADDR_SRQMASK, 32'h0);
        chkreg(ADDR_TRIG, 32'h8);
        chkreg(ADDR_ADDRESS, 32'h5);
        addr = 5'h5;
        bus(1'b0, ADDR_IRQSTAT, 32'h0);
        chk(q & 32'h1, 32'h1);
        chk({31'h0, irq_out}, 32'h0);
        wr(ADDR_IRQMASK, 32'h1);
        @(posedge mclk_in);
        chk({31'h0, irq_out}, 32'h1);
        wr(ADDR_IRQSTAT, 32'h1);
        @(posedge mclk_in);
        chk({31'h0, irq_out}, 32'h0);
        $display("TEST dcl done");
    endtask
    // Selective clear ignored unless listener; sweep kept
    task automatic t_sdc();
        cur = "sdc";
        wr(ADDR_CONFIG, 32'hb3b);
        wr(ADDR_SWEEP, 32'h5a);
        ctrl_inst.send({1'b0, CMD_UNL});
        ctrl_inst.send({1'b0, CMD_SDC});
        repeat (12) @(posedge mclk_in);
        chkreg(ADDR_CONFIG, 32'hb3b);
        ctrl_inst.addressed(addr, CMD_SDC);
        repeat (12) @(posedge mclk_in);
        chk({31'h0, listener_out}, 32'h1);
        chkreg(ADDR_CONFIG, CFG_RESET);
        chkreg(ADDR_SWEEP, 32'h5a);
        factory_init_in <= 1'b1;
        @(posedge mclk_in);
        factory_init_in <= 1'b0;
        chkreg(ADDR_SWEEP, 32'h0);
        $display("TEST sdc done");
    endtask
    // Group trigger qualified by origin and enable; overrun flagged
    task automatic t_get();
        int n;
        cur = "get";
        wr(ADDR_IRQSTAT, 32'hf);
        ctrl_inst.addressed(addr, CMD_GET);
        repeat (2) @(posedge mclk_in);
        chk({30'h0, phase_out}, 32'h0);
        wr(ADDR_TRIG, {29'h0, ORIGIN_GET});
        ctrl_inst.send({1'b0, CMD_GET});
        repeat (2) @(posedge mclk_in);
        chk({30'h0, phase_out}, 32'h0);
        chkreg(ADDR_IRQSTAT, 32'h0);
        wr(ADDR_TRIG, {28'h0, 1'b1, ORIGIN_GET});
        ctrl_inst.send({1'b0, CMD_GET});
        repeat (2) @(posedge mclk_in);
        chk({30'h0, phase_out}, 32'h1);
        ctrl_inst.send({1'b0, CMD_GET});
        bus(1'b0, ADDR_IRQSTAT, 32'h0);
        chk(q & 32'h6, 32'h6);
        n = 0;
        while (phase_out !== 2'h0 && n < 300)
        begin
            @(posedge mclk_in);
            n++;
        end
        chk({31'h0, n > 40 && n < 300}, 32'h1);
        if (n >= 300)
            summarize();
        // Software trigger starts a cycle; a universal clear aborts it
        wr(ADDR_CMD, 32'h1);
        @(posedge mclk_in);
        chk({30'h0, phase_out}, 32'h1);
        ctrl_inst.send({1'b0, CMD_DCL});
        @(posedge mclk_in);
        chk({30'h0, phase_out}, 32'h0);
        $display("TEST get done");
    endtask
    // Serial poll byte carries the service request bit
    task automatic t_poll();
        cur = "poll";
        dev_status_in <= 6'h2a;
        wr(ADDR_SRQMASK, 32'h2);
        ctrl_inst.poll(addr);
        repeat (3) @(posedge mclk_in);
        chk({31'h0, srq_out}, 32'h1);
        chk({24'h0, spoll_byte_out}, 32'h2a | (32'h1 << SPB_SRQ));
        chk({31'h0, spoll_active_out}, 32'h1);
        chk({31'h0, talker_out}, 32'h1);
        chkreg(ADDR_STATUS, 32'h46a);
        wr(ADDR_SRQMASK, 32'h0);
        repeat (3) @(posedge mclk_in);
        chk({24'h0, spoll_byte_out}, 32'h2a);
        ctrl_inst.send({1'b0, CMD_SPD});
        repeat (2) @(posedge mclk_in);
        chk({31'h0, spoll_active_out}, 32'h0);
        $display("TEST poll done");
    endtask
    // Reset for two cycles, then the scenarios in order
    initial
    begin
        n_errors = 0;
        compares = 0;
        addr = ADDR_RESET;
        rst_n_in = 1'b0;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_address_in = 4'h0;
        avs_writedata_in = 32'h0;
        dev_status_in = 6'h00;
        factory_init_in = 1'b0;
        repeat (2) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        t_reset();
        t_dcl();
        t_sdc();
        t_get();
        t_poll();
        summarize();
    end
endmodule
`default_nettype wire
